// ### rtl/swc_pkg.sv
package swc_pkg;

   // register map, byte addresses
   localparam logic [7:0]  REG_STATUS     = 8'h00;
   localparam logic [7:0]  REG_CTRL       = 8'h04;
   localparam logic [7:0]  REG_IRQ_EN     = 8'h08;
   localparam logic [7:0]  REG_IRQ_FLAG   = 8'h0C;

   // status fields
   localparam int          ST_SLEEP_BIT   = 0;
   localparam int          ST_WDT_WAKE    = 1;
   localparam int          ST_IRQ_WAKE    = 2;
   localparam int          ST_PD_BIT      = 3;
   localparam int          ST_TO_BIT      = 4;

   // control fields
   localparam int          CTL_WDT_EN     = 0;
   localparam int          CTL_RC_OSC     = 1;
   localparam int          CTL_GIE        = 2;
   localparam logic [2:0]  CTRL_RESET     = 3'h1;

   // interrupt sources: 0 ext pin, 1 port change, 2..9 sleep-capable
   // peripherals, 10..13 peripherals on the core clock
   localparam int          NUM_IRQ        = 14;
   localparam logic [13:0] WAKE_ELIGIBLE  = 14'h03FF;
   localparam logic [13:0] IRQ_EN_RESET   = 14'h0000;

   // timing
   localparam int          CLK_PERIOD_NS  = 8;
   localparam int          OSC_PERIOD_NS  = 8;
   localparam int          OST_OSC_PERIODS = 1024;
   localparam int          OST_CYCLES     =
      (OST_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          WDT_PERIOD_NS  = 18_000_000;
   localparam int          WDT_CYCLES     = WDT_PERIOD_NS / CLK_PERIOD_NS;

   localparam int          PC_W           = 13;
   localparam logic [12:0] VECTOR_ADDR    = 13'h0004;

   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [1:0] {
      ST_RUN      = 2'b00,
      ST_SLEEP    = 2'b01,
      ST_OSC_WAIT = 2'b10,
      ST_RESUME   = 2'b11
   } swc_state_type;

   typedef struct packed {
      logic [31:0] count;
      logic        expired;
   } swc_wdt_type;

   localparam swc_wdt_type WDT_RESET = '{count: 32'h0000_0000, expired: 1'b0};

   typedef struct packed {
      swc_state_type state;
      logic [10:0]   ost_cnt;
      logic          power_down;
      logic          timeout;
      logic          wdt_wake;
      logic          irq_wake;
      logic [2:0]    ctrl;
      logic [13:0]   irq_en;
      logic          awready;
      logic          wready;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          arready;
      logic          rvalid;
      logic [1:0]    rresp;
      logic [31:0]   rdata;
      logic          wdt_clear;
      logic          osc_drive_en;
      logic          io_hold;
      logic          core_clk_run;
      logic          prefetch_req;
      logic          resume_req;
      logic          vector_req;
      logic [12:0]   vector_addr;
      logic          device_reset;
   } swc_top_type;

   localparam swc_top_type TOP_RESET = '{
      state: ST_RUN, ost_cnt: 11'h000, power_down: 1'b1, timeout: 1'b1,
      wdt_wake: 1'b0, irq_wake: 1'b0, ctrl: CTRL_RESET, irq_en: IRQ_EN_RESET,
      awready: 1'b0, wready: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY,
      arready: 1'b0, rvalid: 1'b0, rresp: RESP_OKAY, rdata: 32'h0000_0000,
      wdt_clear: 1'b0, osc_drive_en: 1'b1, io_hold: 1'b0, core_clk_run: 1'b1,
      prefetch_req: 1'b0, resume_req: 1'b0, vector_req: 1'b0,
      vector_addr: 13'h0000, device_reset: 1'b0};

endpackage : swc_pkg

// ### rtl/swc_watchdog.sv
`timescale 1ns/100ps
module swc_watchdog #(
   parameter int WDT_LIMIT = swc_pkg::WDT_CYCLES
) (
   input  wire logic aclk,      // clock
   input  wire logic aresetn,   // sync reset, active low
   input  wire logic enable,    // watchdog enabled
   input  wire logic clear,     // clear counter
   output logic      expired    // one-cycle expiry pulse
);

   swc_pkg::swc_wdt_type q;
   swc_pkg::swc_wdt_type d;

   // keeps counting whether or not the core clock runs
   always_comb begin
      d         = q;
      d.expired = 1'b0;
      if (clear || !enable) begin
         d.count = 32'h0000_0000;
      end else if (q.count == 32'(WDT_LIMIT - 1)) begin
         d.count   = 32'h0000_0000;
         d.expired = 1'b1;
      end else begin
         d.count = q.count + 32'h0000_0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= swc_pkg::WDT_RESET;
      end else begin
         q <= d;
      end
   end

   assign expired = q.expired;

endmodule : swc_watchdog

// ### rtl/swc_top.sv
// Notes on behaviour
// - sleep instruction enters power-down unless an enabled interrupt is pending.
// - entry clears watchdog, clears power-down flag, sets timeout flag, stops oscillator.
// - ports hold their pre-sleep state throughout power-down.
// - wake on master clear, enabled watchdog expiry, or enabled eligible interrupt.
// - master clear resets the device; other wake events continue execution.
// - watchdog wake clears the timeout flag.
// - power-down flag set at power-up, cleared only by executed sleep.
// - only listed sleep-capable peripheral interrupts may wake the device.
// - core-clocked peripheral interrupts cannot act while asleep.
// - next instruction is prefetched while sleep executes.
// - wake needs the source enable only; global enable is ignored.
// - after interrupt wake run prefetched instruction, then vector 0004h if enabled.
// - pending enabled interrupt makes sleep a no-op; watchdog and flags untouched.
// - interrupt during or after sleep: sleep completes fully, then wakes at once.
// - crystal modes wait 1024 oscillator periods after wake; RC mode none. Here a master clear wake restarts the clock at once.
// - watchdog expiry resets when running, only wakes when asleep; here an expiry in the cycle of a sleep instruction is dropped.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module swc_top #(
   parameter int WDT_LIMIT = swc_pkg::WDT_CYCLES
) (
   input  wire logic        aclk,            // clock
   input  wire logic        aresetn,         // sync reset, active low
   input  wire logic [7:0]  s_axi_awaddr,    // write address
   input  wire logic        s_axi_awvalid,   // write address valid
   output logic             s_axi_awready,   // write address ready
   input  wire logic [31:0] s_axi_wdata,     // write data
   input  wire logic [3:0]  s_axi_wstrb,     // write byte strobes
   input  wire logic        s_axi_wvalid,    // write data valid
   output logic             s_axi_wready,    // write data ready
   output logic [1:0]       s_axi_bresp,     // write response
   output logic             s_axi_bvalid,    // write response valid
   input  wire logic        s_axi_bready,    // write response ready
   input  wire logic [7:0]  s_axi_araddr,    // read address
   input  wire logic        s_axi_arvalid,   // read address valid
   output logic             s_axi_arready,   // read address ready
   output logic [31:0]      s_axi_rdata,     // read data
   output logic [1:0]       s_axi_rresp,     // read response
   output logic             s_axi_rvalid,    // read data valid
   input  wire logic        s_axi_rready,    // read data ready
   input  wire logic        sleep_exec,      // core executes sleep, pulse
   input  wire logic        watchdog_clear_instr, // core executes clear, pulse
   input  wire logic        master_clear_pin_n,   // external reset pin, low active
   input  wire logic [13:0] irq_flags,       // interrupt flags of all sources
   output logic             osc_drive_en,    // oscillator driver on
   output logic             core_clk_run,    // core clock running
   output logic             io_hold,         // freeze port drivers
   output logic             prefetch_req,    // fetch next word, pulse
   output logic             resume_req,      // execute prefetched word, pulse
   output logic             vector_req,      // branch to vector, pulse
   output logic [12:0]      vector_addr,     // branch target
   output logic             device_reset,    // full device reset, pulse
   output logic             watchdog_timer_expired // watchdog expiry, pulse
);

   swc_pkg::swc_top_type q;
   swc_pkg::swc_top_type d;
   logic                 wdt_expired;
   logic                 irq_pending;
   logic                 irq_wake_pending;
   logic                 wdt_hit;
   logic                 wr_go;
   logic                 rd_go;
   logic [2:0]           wr_sel;
   logic [2:0]           rd_sel;

   // one-hot select: status, ctrl, enable, flags; zero when unmapped
   function automatic logic [3:0] reg_sel(input logic [7:0] addr);
      case (addr)
         swc_pkg::REG_STATUS:   reg_sel = 4'h1;
         swc_pkg::REG_CTRL:     reg_sel = 4'h2;
         swc_pkg::REG_IRQ_EN:   reg_sel = 4'h4;
         swc_pkg::REG_IRQ_FLAG: reg_sel = 4'h8;
         default:               reg_sel = 4'h0;
      endcase
   endfunction : reg_sel

   logic [3:0] wsel;
   logic [3:0] rsel;

   swc_watchdog #(
      .WDT_LIMIT (WDT_LIMIT)
   ) u_wdt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (q.ctrl[swc_pkg::CTL_WDT_EN]),
      .clear   (q.wdt_clear),
      .expired (wdt_expired)
   );

   always_comb begin
      wsel    = reg_sel(s_axi_awaddr);
      rsel    = reg_sel(s_axi_araddr);
      wr_sel  = 3'h0;
      rd_sel  = 3'h0;
      // source enable alone decides, global enable plays no part
      irq_pending      = |(irq_flags & q.irq_en);
      // core-clocked sources masked off while asleep
      irq_wake_pending = |(irq_flags & q.irq_en & swc_pkg::WAKE_ELIGIBLE);
      wdt_hit = wdt_expired && q.ctrl[swc_pkg::CTL_WDT_EN];
      wr_go   = s_axi_awvalid && s_axi_wvalid && !q.bvalid && !q.awready;
      rd_go   = s_axi_arvalid && !q.rvalid && !q.arready;

      d              = q;
      d.wdt_clear    = watchdog_clear_instr;
      d.prefetch_req = 1'b0;
      d.resume_req   = 1'b0;
      d.vector_req   = 1'b0;
      d.device_reset = 1'b0;

      if (!master_clear_pin_n) begin
         // external reset at any time, asleep or not
         d.device_reset = 1'b1;
         d.state        = swc_pkg::ST_RUN;
         d.osc_drive_en = 1'b1;
         d.core_clk_run = 1'b1;
         d.io_hold      = 1'b0;
      end else begin
         case (q.state)
            swc_pkg::ST_RUN: begin
               if (sleep_exec && irq_pending) begin
                  // no-op: watchdog and both flags left alone
                  d.wdt_clear = watchdog_clear_instr;
               end else if (sleep_exec) begin
                  d.state        = swc_pkg::ST_SLEEP;
                  d.wdt_clear    = 1'b1;
                  d.power_down   = 1'b0;
                  d.timeout      = 1'b1;
                  d.osc_drive_en = 1'b0;
                  d.core_clk_run = 1'b0;
                  d.io_hold      = 1'b1;
                  d.prefetch_req = 1'b1;
                  d.wdt_wake     = 1'b0;
                  d.irq_wake     = 1'b0;
               end else if (wdt_hit) begin
                  d.device_reset = 1'b1;
                  d.timeout      = 1'b0;
               end
            end
            swc_pkg::ST_SLEEP: begin
               // watched on aclk while the core clock is stopped
               if (wdt_hit || irq_wake_pending) begin
                  d.wdt_wake     = wdt_hit;
                  d.irq_wake     = !wdt_hit;
                  d.timeout      = !wdt_hit;
                  d.osc_drive_en = 1'b1;
                  d.ost_cnt      = 11'h000;
                  d.state        = q.ctrl[swc_pkg::CTL_RC_OSC] ?
                                   swc_pkg::ST_RESUME : swc_pkg::ST_OSC_WAIT;
               end
            end
            swc_pkg::ST_OSC_WAIT: begin
               if (q.ost_cnt == 11'(swc_pkg::OST_CYCLES - 1)) begin
                  d.state = swc_pkg::ST_RESUME;
               end else begin
                  d.ost_cnt = q.ost_cnt + 11'h001;
               end
            end
            swc_pkg::ST_RESUME: begin
               // continue, no reset: prefetched word first, then vector
               d.state        = swc_pkg::ST_RUN;
               d.core_clk_run = 1'b1;
               d.io_hold      = 1'b0;
               d.resume_req   = 1'b1;
               d.vector_req   = q.irq_wake && q.ctrl[swc_pkg::CTL_GIE];
               d.vector_addr  = swc_pkg::VECTOR_ADDR;
            end
            default: begin
               d.state = swc_pkg::ST_RUN;
            end
         endcase
      end

      // write channel: address and data taken together
      d.awready = wr_go;
      d.wready  = wr_go;
      if (wr_go) begin
         d.bvalid = 1'b1;
         d.bresp  = (wsel == 4'h0) ? swc_pkg::RESP_SLVERR : swc_pkg::RESP_OKAY;
         wr_sel   = wsel[2:0];
         if (wr_sel[1] && s_axi_wstrb[0]) begin
            d.ctrl = s_axi_wdata[2:0];
         end
         if (wr_sel[2] && s_axi_wstrb[0]) begin
            d.irq_en[7:0] = s_axi_wdata[7:0];
         end
         if (wr_sel[2] && s_axi_wstrb[1]) begin
            d.irq_en[13:8] = s_axi_wdata[13:8];
         end
      end else if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // read channel
      d.arready = rd_go;
      if (rd_go) begin
         d.rvalid = 1'b1;
         d.rresp  = (rsel == 4'h0) ? swc_pkg::RESP_SLVERR : swc_pkg::RESP_OKAY;
         d.rdata  = 32'h0000_0000;
         rd_sel   = rsel[2:0];
         if (rsel[0]) begin
            d.rdata[swc_pkg::ST_SLEEP_BIT] = (q.state != swc_pkg::ST_RUN);
            d.rdata[swc_pkg::ST_WDT_WAKE]  = q.wdt_wake;
            d.rdata[swc_pkg::ST_IRQ_WAKE]  = q.irq_wake;
            d.rdata[swc_pkg::ST_PD_BIT]    = q.power_down;
            d.rdata[swc_pkg::ST_TO_BIT]    = q.timeout;
         end
         if (rd_sel[1]) begin
            d.rdata[2:0] = q.ctrl;
         end
         if (rd_sel[2]) begin
            d.rdata[13:0] = q.irq_en;
         end
         if (rsel[3]) begin
            d.rdata[13:0] = irq_flags;
         end
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= swc_pkg::TOP_RESET;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready          = q.awready;
   assign s_axi_wready           = q.wready;
   assign s_axi_bvalid           = q.bvalid;
   assign s_axi_bresp            = q.bresp;
   assign s_axi_arready          = q.arready;
   assign s_axi_rvalid           = q.rvalid;
   assign s_axi_rresp            = q.rresp;
   assign s_axi_rdata            = q.rdata;
   assign osc_drive_en           = q.osc_drive_en;
   assign core_clk_run           = q.core_clk_run;
   assign io_hold                = q.io_hold;
   assign prefetch_req           = q.prefetch_req;
   assign resume_req             = q.resume_req;
   assign vector_req             = q.vector_req;
   assign vector_addr            = q.vector_addr;
   assign device_reset           = q.device_reset;
   assign watchdog_timer_expired = wdt_expired;

endmodule : swc_top

// ### tb/swc_props.sv
`timescale 1ns/100ps
module swc_props #(
   parameter int WDT_LIMIT = 16
) (
   input wire logic        aclk,                   // clock
   input wire logic        aresetn,                // sync reset, active low
   input wire logic        sleep_exec,             // sleep pulse
   input wire logic        master_clear_pin_n,     // external reset pin
   input wire logic        osc_drive_en,           // oscillator on
   input wire logic        core_clk_run,           // core clock on
   input wire logic        io_hold,                // ports frozen
   input wire logic        prefetch_req,           // entry pulse
   input wire logic        resume_req,             // resume pulse
   input wire logic        vector_req,             // branch pulse
   input wire logic [12:0] vector_addr,            // branch target
   input wire logic        device_reset,           // reset pulse
   input wire logic        watchdog_timer_expired  // expiry pulse
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_entry_outputs: assert property (prefetch_req |-> !osc_drive_en && io_hold && !core_clk_run)
      else $error("sleep entry outputs wrong");
   a_entry_cause: assert property (prefetch_req |-> $past(sleep_exec))
      else $error("entry without sleep");
   a_osc_stop_cause: assert property ($fell(osc_drive_en) |-> prefetch_req)
      else $error("oscillator stopped outside entry");
   a_ports_frozen: assert property (!core_clk_run |-> io_hold)
      else $error("ports released while asleep");
   a_dog_cleared: assert property (prefetch_req |=> !watchdog_timer_expired [*8])
      else $error("watchdog not cleared on entry");
   a_vector_branch: assert property (vector_req |-> resume_req ##1 vector_addr == 13'h0004)
      else $error("vector branch wrong");
   a_resume_outputs: assert property (resume_req |-> core_clk_run && !io_hold && osc_drive_en)
      else $error("resume outputs wrong");
   a_pin_reset: assert property (!master_clear_pin_n |-> ##[0:1] device_reset)
      else $error("no reset from pin");
   a_osc_first: assert property ($rose(core_clk_run) && !device_reset |-> $past(osc_drive_en))
      else $error("clock before oscillator");
   a_run_expiry: assert property (watchdog_timer_expired && core_clk_run && !prefetch_req
      |-> ##[0:2] device_reset)
      else $error("running expiry without reset");

   // cycles since the last sleep entry, saturating
   logic [11:0] nap_len_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || prefetch_req) begin
         nap_len_q <= 12'h000;
      end else if (nap_len_q != 12'hFFF) begin
         nap_len_q <= nap_len_q + 12'h001;
      end
   end

   c_vector: cover property (vector_req);
   c_wake: cover property (resume_req && nap_len_q <= 12'h044B);
   c_pin: cover property (device_reset && !master_clear_pin_n);
endmodule : swc_props

bind swc_top swc_props #(.WDT_LIMIT(WDT_LIMIT)) swc_props_inst (.aclk, .aresetn, .sleep_exec,
   .master_clear_pin_n, .osc_drive_en, .core_clk_run, .io_hold, .prefetch_req, .resume_req,
   .vector_req, .vector_addr, .device_reset, .watchdog_timer_expired);

// ### tb/swc_core_model.sv
`timescale 1ns/100ps
module swc_core_model (
   input  wire logic aclk,                       // clock
   input  wire logic aresetn,                    // sync reset, active low
   input  wire logic sleep_cmd,                  // bench asks for a sleep
   input  wire logic core_clk_run,               // core clock gate
   output logic      sleep_exec = 1'b0,          // sleep instruction pulse
   output logic      watchdog_clear_instr        // clear instruction pulse
);
   assign watchdog_clear_instr = 1'b0;
   // a stopped core cannot issue anything
   always @(posedge aclk) begin
      sleep_exec <= aresetn && sleep_cmd && core_clk_run && !sleep_exec;
   end
endmodule : swc_core_model

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
   localparam int LIM = 40;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic sleep_cmd = 1'b0, master_clear_pin_n = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic [13:0] irq_flags = 14'h0000;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic sleep_exec, watchdog_clear_instr, osc_drive_en, core_clk_run, io_hold;
   logic prefetch_req, resume_req, vector_req, device_reset, watchdog_timer_expired;
   logic [12:0] vector_addr;
   int n_errors = 0;
   int total_checks = 0;
   logic [65:0] rq[$];
   logic [1:0] bq[$];
   logic vq[$];
   logic [31:0] seed = 32'h0000_005B;

   always #4 aclk = ~aclk;

   swc_top #(.WDT_LIMIT(LIM)) swc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_exec, .watchdog_clear_instr,
      .master_clear_pin_n, .irq_flags, .osc_drive_en, .core_clk_run, .io_hold, .prefetch_req,
      .resume_req, .vector_req, .vector_addr, .device_reset, .watchdog_timer_expired);
   swc_core_model swc_core_model_inst (.aclk, .aresetn, .sleep_cmd, .core_clk_run, .sleep_exec,
      .watchdog_clear_instr);

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      if (n_errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   task automatic tmo();
      n_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      wrap_up();
   endtask : tmo

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                     input logic [1:0] r = swc_pkg::RESP_OKAY);
      int i;
      @(posedge aclk);
      rq.push_back({m, r, d & m});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (i == 20) tmo();
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = swc_pkg::RESP_OKAY);
      int i;
      @(posedge aclk);
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (i == 20) tmo();
   endtask : wr

   task automatic slp();
      @(posedge aclk);
      sleep_cmd <= 1'b1;
      @(posedge aclk);
      sleep_cmd <= 1'b0;
   endtask : slp

   task automatic wait_res(input int lim, output int n);
      for (n = 0; n < lim; n++) begin
         @(posedge aclk);
         if (resume_req) break;
      end
      if (n == lim) tmo();
   endtask : wait_res

   always @(posedge aclk) begin
      logic [65:0] e;
      if (s_axi_rvalid && s_axi_rready) begin
         e = rq.pop_front();
         check({s_axi_rresp, s_axi_rdata & e[65:34]}, e[33:0]);
      end
      if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(bq.pop_front()));
      if (resume_req) check(34'(vector_req), 34'(vq.pop_front()));
   end

   initial begin
      int n;
      int k;
      tick(2);
      aresetn <= 1'b1;
      rd(swc_pkg::REG_STATUS, 32'h0000_001F, 32'h0000_0018);
      rd(swc_pkg::REG_CTRL, 32'h0000_0007, 32'h0000_0001);
      wr(swc_pkg::REG_CTRL, 32'h0000_0000);
      // pending enabled flag turns sleep into nothing
      wr(swc_pkg::REG_IRQ_EN, 32'h0000_0001);
      irq_flags <= 14'h0001;
      slp();
      tick(4);
      check(34'(core_clk_run), 34'h1);
      rd(swc_pkg::REG_STATUS, 32'h0000_0019, 32'h0000_0018);
      // rc mode, core-clocked source ignored, port change wakes without global enable
      irq_flags <= 14'h0000;
      wr(swc_pkg::REG_CTRL, 32'h0000_0002);
      wr(swc_pkg::REG_IRQ_EN, 32'h0000_0402);
      slp();
      tick(3);
      irq_flags <= 14'h0400;
      tick(30);
      check(34'(core_clk_run), 34'h0);
      vq.push_back(1'b0);
      irq_flags <= 14'h0402;
      wait_res(10, n);
      check(34'(n <= 4), 34'h1);
      irq_flags <= 14'h0000;
      // crystal mode, random eligible peripheral, global enable set
      seed = xs(seed);
      k = 2 + int'(seed[2:0]);
      wr(swc_pkg::REG_CTRL, 32'h0000_0004);
      wr(swc_pkg::REG_IRQ_EN, 32'h0000_0001 << k);
      slp();
      tick(3);
      rd(swc_pkg::REG_STATUS, 32'h0000_0019, 32'h0000_0011);
      vq.push_back(1'b1);
      irq_flags <= 14'h0001 << k;
      wait_res(1100, n);
      check(34'(n >= 1024), 34'h1);
      irq_flags <= 14'h0000;
      rd(swc_pkg::REG_STATUS, 32'h0000_001F, 32'h0000_0014);
      // watchdog wakes when asleep, resets when running
      wr(swc_pkg::REG_CTRL, 32'h0000_0003);
      slp();
      vq.push_back(1'b0);
      wait_res(LIM + 20, n);
      rd(swc_pkg::REG_STATUS, 32'h0000_001B, 32'h0000_0002);
      for (n = 0; n < LIM + 20 && device_reset !== 1'b1; n++) @(posedge aclk);
      check(34'(device_reset), 34'h1);
      // pin reset during sleep
      wr(swc_pkg::REG_CTRL, 32'h0000_0002);
      slp();
      tick(4);
      master_clear_pin_n <= 1'b0;
      tick(3);
      check(34'(device_reset), 34'h1);
      check(34'(core_clk_run), 34'h1);
      master_clear_pin_n <= 1'b1;
      rd(8'h10, 32'hFFFF_FFFF, 32'h0000_0000, swc_pkg::RESP_SLVERR);
      wr(8'h10, 32'h0000_0007, swc_pkg::RESP_SLVERR);
      rd(swc_pkg::REG_CTRL, 32'h0000_0007, 32'h0000_0002);
      tick(2);
      wrap_up();
   end
endmodule : testbench
